//--- rtl/dtl_regs.vh
// Register offsets, field positions and reset values of the test link bank.
// How it works
// - Data write pushes value into selected block
// - Data read returns selected block register contents
// - Output mode 00 disables, 10 enables outputs
// - Pin config 1 uses pin, 0 uses bits
// - Self-test start writes clock source to remote
// - Self-test enable bit starts test, resets off
// - Index strap decoded, latched, done flag set
// - Mode strap decoded, latched, done flag set
// - Filter-wait bit masks errors during wait period
// - Control bit enables forward-link error counting
// - Counting on: lose lock at threshold, default 3
// - Counting off: lose lock on first error
// - Parity, clock and control violations count errors
// - CRC enabled: failing packets never update link info
// - Four-bit select picks indirect target block
// - Auto-increment bumps offset after each access
`ifndef DTL_REGS_VH
`define DTL_REGS_VH
`define DTL_ADDR_IND_CTL 8'hB0
`define DTL_ADDR_IND_OFS 8'hB1
`define DTL_ADDR_IND_DATA 8'hB2
`define DTL_ADDR_TEST_CTL 8'hB3
`define DTL_ADDR_SPARE_B4 8'hB4
`define DTL_ADDR_SPARE_B5 8'hB5
`define DTL_ADDR_SPARE_B6 8'hB6
`define DTL_ADDR_SPARE_B7 8'hB7
`define DTL_ADDR_STRAP_STS 8'hB8
`define DTL_ADDR_ERR_POLICY 8'hB9
`define DTL_ADDR_CRC_CTL 8'hBA
`define DTL_ADDR_SPARE_BB 8'hBB
`define DTL_RST_IND_CTL 6'h00
`define DTL_RST_IND_OFS 8'h00
`define DTL_RST_IND_DATA 8'h00
`define DTL_RST_TEST_CTL 8'h08
`define DTL_RST_SPARE_B4 8'h25
`define DTL_RST_SPARE_B5 8'h00
`define DTL_RST_SPARE_B6 8'h18
`define DTL_RST_SPARE_B7 8'h00
`define DTL_RST_ERR_POLICY 6'h33
`define DTL_RST_CRC_CTL 8'h83
`define DTL_RST_SPARE_BB 8'h74
`define DTL_IND_SEL_HI 5
`define DTL_IND_SEL_LO 2
`define DTL_IND_AUTOINC 1
`define DTL_IND_PREFETCH 0
`define DTL_TST_MODE_HI 7
`define DTL_TST_MODE_LO 6
`define DTL_TST_PIN_CFG 3
`define DTL_TST_CLK_HI 2
`define DTL_TST_CLK_LO 1
`define DTL_TST_EN 0
`define DTL_TST_MODE_OFF 2'h0
`define DTL_TST_MODE_ON 2'h2
`define DTL_ERR_WAIT_MASK 5
`define DTL_ERR_CNT_EN 4
`define DTL_ERR_THR_HI 3
`define DTL_ERR_THR_LO 0
`define DTL_CRC_DIS 7
`define DTL_REMOTE_CLK_OFS 8'h14
`define DTL_STRAP_SETTLE 4'h8
`define DTL_ZERO8 8'h00
`define DTL_ONE8 8'h01
`endif

//--- rtl/dtl_sync2.v
// Two-stage synchroniser for pin-level inputs.
`timescale 1ns/1ps
`default_nettype none
module dtl_sync2 #(
   parameter W = 1
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);
   reg [W-1:0] meta;

   // The first stage feeds only the second stage.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else if (i_ce) begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule // dtl_sync2
`default_nettype wire

//--- rtl/dtl_lock_mon.v
// Forward-link error counter that decides loss of lock.
`timescale 1ns/1ps
`default_nettype none
module dtl_lock_mon (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_lock_detect,
   input wire i_err_parity,
   input wire i_err_clock,
   input wire i_err_ctrl,
   input wire i_filter_wait,
   input wire i_wait_mask,
   input wire i_count_en,
   input wire [3:0] i_threshold,
   output reg o_locked,
   output reg o_lock_lost,
   output reg [3:0] o_err_count
);
   reg dropped;
   wire any_err;
   wire err_hit;
   wire [4:0] next_count;
   wire reach;

   // Any forward-link violation is an error.
   assign any_err = i_err_parity | i_err_clock | i_err_ctrl;
   // Errors in the filter wait window are masked when asked.
   assign err_hit = any_err & o_locked & ~(i_wait_mask & i_filter_wait);
   assign next_count = {1'b0, o_err_count} + 5'h01;
   // Threshold compare, or first error when counting is off.
   assign reach = ~i_count_en | (next_count >= {1'b0, i_threshold});

   // Lock follows the detector until errors drop it; relock needs a
   // fresh detect so a dropped link is not silently resumed.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dropped <= 1'b0;
         o_locked <= 1'b0;
         o_lock_lost <= 1'b0;
         o_err_count <= 4'h0;
      end else if (i_ce) begin
         o_lock_lost <= 1'b0;
         if (!i_lock_detect) begin
            dropped <= 1'b0;
         end else if (err_hit && reach) begin
            dropped <= 1'b1;
            o_lock_lost <= 1'b1;
         end
         o_locked <= i_lock_detect & ~dropped & ~(err_hit & reach);
         // Held at zero while unlocked, so every lock starts a fresh count.
         if (!o_locked) begin
            o_err_count <= 4'h0;
         end else if (err_hit && i_count_en && !reach) begin
            o_err_count <= next_count[3:0];
         end
      end
   end
endmodule // dtl_lock_mon
`default_nettype wire

//--- rtl/dtl_ctrl.v
// Test and link control register bank with indirect access port.
`timescale 1ns/1ps
`default_nettype none
`include "dtl_regs.vh"
module dtl_ctrl (
   input wire I_CLK_SYS,
   input wire I_RST_N,
   input wire I_CE,
   input wire I_REG_WR,
   input wire I_REG_RD,
   input wire [7:0] I_REG_ADDR,
   input wire [7:0] I_REG_WDATA,
   output reg [7:0] O_REG_RDATA,
   output wire [3:0] O_IND_SEL,
   output wire [7:0] O_IND_ADDR,
   output wire [7:0] O_IND_WDATA,
   output reg O_IND_WR,
   output reg O_IND_RD,
   input wire [7:0] I_IND_RDATA,
   input wire I_TEST_PIN,
   output reg O_TEST_ACTIVE,
   output reg O_OUT_ENABLE,
   output reg O_REMOTE_REQ,
   output wire [7:0] O_REMOTE_ADDR,
   output reg [7:0] O_REMOTE_DATA,
   input wire I_REMOTE_ACK,
   input wire [2:0] I_INDEX_STRAP,
   input wire [2:0] I_MODE_STRAP,
   input wire I_LOCK_DETECT,
   input wire I_ERR_PARITY,
   input wire I_ERR_CLOCK,
   input wire I_ERR_CTRL,
   input wire I_FILTER_WAIT,
   output wire O_LOCKED,
   output wire O_LOCK_LOST,
   input wire I_PKT_VALID,
   input wire I_PKT_CRC_OK,
   input wire [7:0] I_PKT_INFO,
   output reg [7:0] O_LINK_INFO,
   output reg O_PKT_DROPPED
);
   // Stored register fields.
   reg [5:0] ind_ctl;
   reg [7:0] ind_ofs;
   reg [7:0] indirect_data;
   reg [7:0] test_ctl;
   reg [7:0] spare_b4;
   reg [7:0] spare_b5;
   reg [7:0] spare_b6;
   reg [7:0] spare_b7;
   reg [5:0] err_policy;
   reg [7:0] crc_ctl;
   reg [7:0] spare_bb;
   // Strap latches, their settle counter and the self-test edge flop.
   reg [2:0] index_strap_value;
   reg [2:0] mode_strap_value;
   reg index_strap_done;
   reg mode_strap_done;
   reg [3:0] settle;
   reg test_active_d;
   reg [7:0] next_rdata;
   // Synchronised pins and decoded access strobes.
   wire [6:0] pin_sync;
   wire test_pin;
   wire [2:0] index_sync;
   wire [2:0] mode_sync;
   wire wr_ind_ofs;
   wire wr_ind_data;
   wire rd_ind_data;
   wire indirect_offset_autoinc;
   wire prefetch;
   wire test_start;
   wire [3:0] err_count;

   // Pins from outside the clock domain pass two flops first.
   dtl_sync2 #(
      .W(7)
   ) u_pin_sync (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_async({I_TEST_PIN, I_INDEX_STRAP, I_MODE_STRAP}),
      .o_sync(pin_sync)
   );
   // The strap pins ride the same synchroniser as the test pin.
   assign test_pin = pin_sync[6];
   assign index_sync = pin_sync[5:3];
   assign mode_sync = pin_sync[2:0];

   // Access strobes for the indirect port.
   assign wr_ind_ofs = I_REG_WR & (I_REG_ADDR == `DTL_ADDR_IND_OFS);
   assign wr_ind_data = I_REG_WR & (I_REG_ADDR == `DTL_ADDR_IND_DATA);
   assign rd_ind_data = I_REG_RD & (I_REG_ADDR == `DTL_ADDR_IND_DATA);
   assign indirect_offset_autoinc = ind_ctl[`DTL_IND_AUTOINC];
   assign prefetch = ind_ctl[`DTL_IND_PREFETCH];

   // The selected block and offset go straight to the internal blocks.
   assign O_IND_SEL = ind_ctl[`DTL_IND_SEL_HI:`DTL_IND_SEL_LO];
   assign O_IND_ADDR = ind_ofs;
   assign O_IND_WDATA = indirect_data;
   assign O_REMOTE_ADDR = `DTL_REMOTE_CLK_OFS;

   // Register writes; the offset also moves after indirect accesses.
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ind_ctl <= `DTL_RST_IND_CTL;
         ind_ofs <= `DTL_RST_IND_OFS;
         indirect_data <= `DTL_RST_IND_DATA;
         test_ctl <= `DTL_RST_TEST_CTL;
         spare_b4 <= `DTL_RST_SPARE_B4;
         spare_b5 <= `DTL_RST_SPARE_B5;
         spare_b6 <= `DTL_RST_SPARE_B6;
         spare_b7 <= `DTL_RST_SPARE_B7;
         err_policy <= `DTL_RST_ERR_POLICY;
         crc_ctl <= `DTL_RST_CRC_CTL;
         spare_bb <= `DTL_RST_SPARE_BB;
      end else if (I_CE) begin
         // Reserved bits of the select and policy registers are not
         // stored; the status register and unmapped offsets ignore writes.
         if (I_REG_WR) begin
            if (I_REG_ADDR == `DTL_ADDR_IND_CTL) begin
               ind_ctl <= I_REG_WDATA[5:0];
            end else if (I_REG_ADDR == `DTL_ADDR_IND_DATA) begin
               indirect_data <= I_REG_WDATA;
            end else if (I_REG_ADDR == `DTL_ADDR_TEST_CTL) begin
               test_ctl <= I_REG_WDATA;
            end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B4) begin
               spare_b4 <= I_REG_WDATA;
            end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B5) begin
               spare_b5 <= I_REG_WDATA;
            end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B6) begin
               spare_b6 <= I_REG_WDATA;
            end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B7) begin
               spare_b7 <= I_REG_WDATA;
            end else if (I_REG_ADDR == `DTL_ADDR_ERR_POLICY) begin
               err_policy <= I_REG_WDATA[5:0];
            end else if (I_REG_ADDR == `DTL_ADDR_CRC_CTL) begin
               crc_ctl <= I_REG_WDATA;
            end else if (I_REG_ADDR == `DTL_ADDR_SPARE_BB) begin
               spare_bb <= I_REG_WDATA;
            end
         end
         // An offset write wins over an increment in the same cycle.
         // After a data write the offset moves only with the strobe, so
         // the block is written at the offset that was selected.
         // A read in that very cycle shares the single increment.
         if (wr_ind_ofs) begin
            ind_ofs <= I_REG_WDATA;
         end else if ((O_IND_WR || rd_ind_data) &&
                      indirect_offset_autoinc) begin
            ind_ofs <= ind_ofs + `DTL_ONE8;
         end
      end
   end

   // Indirect strobes: a write follows a data write by one cycle so
   // the block sees the freshly stored value; reads may prefetch.
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_IND_WR <= 1'b0;
         O_IND_RD <= 1'b0;
      end else if (I_CE) begin
         O_IND_WR <= wr_ind_data;
         O_IND_RD <= prefetch & (wr_ind_ofs |
                     (rd_ind_data & indirect_offset_autoinc));
      end
   end

   // Read multiplexer; unmapped offsets read as zero.
   always @* begin
      next_rdata = `DTL_ZERO8;
      if (I_REG_ADDR == `DTL_ADDR_IND_CTL) begin
         next_rdata = {2'b00, ind_ctl};
      end else if (I_REG_ADDR == `DTL_ADDR_IND_OFS) begin
         next_rdata = ind_ofs;
      end else if (I_REG_ADDR == `DTL_ADDR_IND_DATA) begin
         next_rdata = I_IND_RDATA;
      end else if (I_REG_ADDR == `DTL_ADDR_TEST_CTL) begin
         next_rdata = test_ctl;
      end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B4) begin
         next_rdata = spare_b4;
      end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B5) begin
         next_rdata = spare_b5;
      end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B6) begin
         next_rdata = spare_b6;
      end else if (I_REG_ADDR == `DTL_ADDR_SPARE_B7) begin
         next_rdata = spare_b7;
      end else if (I_REG_ADDR == `DTL_ADDR_STRAP_STS) begin
         // Each done flag sits just above its decoded value.
         next_rdata = {index_strap_done, index_strap_value,
                       mode_strap_done, mode_strap_value};
      end else if (I_REG_ADDR == `DTL_ADDR_ERR_POLICY) begin
         next_rdata = {2'b00, err_policy};
      end else if (I_REG_ADDR == `DTL_ADDR_CRC_CTL) begin
         next_rdata = crc_ctl;
      end else if (I_REG_ADDR == `DTL_ADDR_SPARE_BB) begin
         next_rdata = spare_bb;
      end
   end

   // Read data is registered on the read strobe and held until the next.
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_REG_RDATA <= `DTL_ZERO8;
      end else if (I_CE && I_REG_RD) begin
         O_REG_RDATA <= next_rdata;
      end
   end

   // Strap decodes are caught once the synchronisers have settled.
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         settle <= 4'h0;
         index_strap_value <= 3'h0;
         mode_strap_value <= 3'h0;
         index_strap_done <= 1'b0;
         mode_strap_done <= 1'b0;
      end else if (I_CE) begin
         // The latch is taken once; later pin changes are not seen.
         if (settle != `DTL_STRAP_SETTLE) begin
            settle <= settle + 4'h1;
         end else if (!index_strap_done) begin
            index_strap_value <= index_sync;
            mode_strap_value <= mode_sync;
            index_strap_done <= 1'b1;
            mode_strap_done <= 1'b1;
         end
      end
   end

   // Self-test source, output gating and remote clock-source push.
   assign test_start = O_TEST_ACTIVE & ~test_active_d;
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_TEST_ACTIVE <= 1'b0;
         test_active_d <= 1'b0;
         O_OUT_ENABLE <= 1'b1;
         O_REMOTE_REQ <= 1'b0;
         O_REMOTE_DATA <= `DTL_ZERO8;
      end else if (I_CE) begin
         // The pin arrives already synchronised; the bit picks the source.
         if (test_ctl[`DTL_TST_PIN_CFG]) begin
            O_TEST_ACTIVE <= test_pin;
         end else begin
            O_TEST_ACTIVE <= test_ctl[`DTL_TST_EN];
         end
         test_active_d <= O_TEST_ACTIVE;
         // Reserved codes gate outputs like the disabled code.
         O_OUT_ENABLE <= ~O_TEST_ACTIVE |
            (test_ctl[`DTL_TST_MODE_HI:`DTL_TST_MODE_LO] ==
             `DTL_TST_MODE_ON);
         // A fresh start wins over a late acknowledge, so no push is lost.
         if (test_start) begin
            O_REMOTE_REQ <= 1'b1;
            O_REMOTE_DATA <= {6'h00,
               test_ctl[`DTL_TST_CLK_HI:`DTL_TST_CLK_LO]};
         end else if (I_REMOTE_ACK) begin
            O_REMOTE_REQ <= 1'b0;
         end
      end
   end

   // Link information only updates from packets that pass or skip CRC.
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_LINK_INFO <= `DTL_ZERO8;
         O_PKT_DROPPED <= 1'b0;
      end else if (I_CE) begin
         O_PKT_DROPPED <= 1'b0;
         // A failing packet leaves the last good info in place.
         if (I_PKT_VALID) begin
            if (crc_ctl[`DTL_CRC_DIS] || I_PKT_CRC_OK) begin
               O_LINK_INFO <= I_PKT_INFO;
            end else begin
               O_PKT_DROPPED <= 1'b1;
            end
         end
      end
   end

   // Lock decision from the forward-link error policy.
   // The running error count comes out of the monitor but no register reads it.
   dtl_lock_mon u_lock (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_lock_detect(I_LOCK_DETECT),
      .i_err_parity(I_ERR_PARITY),
      .i_err_clock(I_ERR_CLOCK),
      .i_err_ctrl(I_ERR_CTRL),
      .i_filter_wait(I_FILTER_WAIT),
      .i_wait_mask(err_policy[`DTL_ERR_WAIT_MASK]),
      .i_count_en(err_policy[`DTL_ERR_CNT_EN]),
      .i_threshold(err_policy[`DTL_ERR_THR_HI:`DTL_ERR_THR_LO]),
      .o_locked(O_LOCKED),
      .o_lock_lost(O_LOCK_LOST),
      .o_err_count(err_count)
   );
endmodule // dtl_ctrl
`default_nettype wire

//--- sim/dtl_remote_model.sv
// Remote serializer model that takes the clock-source write.
`timescale 1ns/1ps
`default_nettype none
module dtl_remote_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_delay,
   input wire logic i_req,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_data,
   output logic o_ack,
   output logic [7:0] o_clk_src
);
   logic [3:0] wait_cnt;
   // Accepts a pending write after the chosen delay, one ack per request.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ack <= 1'b0;
         wait_cnt <= 4'h0;
         o_clk_src <= 8'hFF;
      end else if (o_ack || !i_req) begin
         o_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= i_delay) begin
         o_ack <= 1'b1;
         if (i_addr == 8'h14) o_clk_src <= i_data;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // dtl_remote_model
`default_nettype wire

//--- sim/dtl_ctrl_asserts.sv
// Concurrent checks on the ports of the control register bank.
`timescale 1ns/1ps
`default_nettype none
module dtl_ctrl_asserts (
   input wire I_CLK_SYS,
   input wire I_RST_N,
   input wire I_CE,
   input wire I_REG_WR,
   input wire I_REG_RD,
   input wire [7:0] I_REG_ADDR,
   input wire [7:0] I_REG_WDATA,
   input wire [7:0] O_REG_RDATA,
   input wire O_IND_WR,
   input wire [7:0] O_IND_WDATA,
   input wire [7:0] I_IND_RDATA,
   input wire O_TEST_ACTIVE,
   input wire O_OUT_ENABLE,
   input wire O_REMOTE_REQ,
   input wire [7:0] O_REMOTE_ADDR,
   input wire [7:0] O_REMOTE_DATA,
   input wire I_REMOTE_ACK,
   input wire O_LOCKED,
   input wire O_LOCK_LOST,
   input wire I_PKT_VALID,
   input wire I_PKT_CRC_OK,
   input wire [7:0] I_PKT_INFO,
   input wire [7:0] O_LINK_INFO,
   input wire O_PKT_DROPPED
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   property p_ind_wr;
      I_CE && I_REG_WR && I_REG_ADDR == 8'hB2
         |=> O_IND_WR && O_IND_WDATA == $past(I_REG_WDATA);
   endproperty
   a_ind_wr: assert property (p_ind_wr) else $error("indirect write");
   property p_ind_rd;
      I_CE && I_REG_RD && I_REG_ADDR == 8'hB2
         |=> O_REG_RDATA == $past(I_IND_RDATA);
   endproperty
   a_ind_rd: assert property (p_ind_rd) else $error("indirect read");
   property p_out_en;
      !O_TEST_ACTIVE ##1 !O_TEST_ACTIVE |-> O_OUT_ENABLE;
   endproperty
   a_out_en: assert property (p_out_en) else $error("outputs off");
   property p_req_rise;
      $rose(O_TEST_ACTIVE) && I_CE |=> O_REMOTE_REQ;
   endproperty
   a_req_rise: assert property (p_req_rise) else $error("no remote req");
   property p_req_addr;
      O_REMOTE_REQ |-> O_REMOTE_ADDR == 8'h14 && O_REMOTE_DATA[7:2] == 6'h00;
   endproperty
   a_req_addr: assert property (p_req_addr) else $error("remote target");
   property p_req_hold;
      O_REMOTE_REQ && !I_REMOTE_ACK |=> O_REMOTE_REQ && $stable(O_REMOTE_DATA);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("req not held");
   property p_lost;
      O_LOCK_LOST |-> $past(O_LOCKED) && !O_LOCKED ##1 !O_LOCK_LOST;
   endproperty
   a_lost: assert property (p_lost) else $error("lock lost pulse");
   property p_pkt_ok;
      I_CE && I_PKT_VALID && I_PKT_CRC_OK
         |=> O_LINK_INFO == $past(I_PKT_INFO) && !O_PKT_DROPPED;
   endproperty
   a_pkt_ok: assert property (p_pkt_ok) else $error("good packet");
   property p_drop;
      O_PKT_DROPPED |-> $stable(O_LINK_INFO) && $past(I_PKT_VALID)
         && !$past(I_PKT_CRC_OK);
   endproperty
   a_drop: assert property (p_drop) else $error("bad drop");
endmodule // dtl_ctrl_asserts
bind dtl_ctrl dtl_ctrl_asserts dtl_ctrl_asserts_i (.I_CLK_SYS(I_CLK_SYS),
   .I_RST_N(I_RST_N), .I_CE(I_CE), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
   .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
   .O_REG_RDATA(O_REG_RDATA), .O_IND_WR(O_IND_WR), .O_IND_WDATA(O_IND_WDATA),
   .I_IND_RDATA(I_IND_RDATA), .O_TEST_ACTIVE(O_TEST_ACTIVE),
   .O_OUT_ENABLE(O_OUT_ENABLE), .O_REMOTE_REQ(O_REMOTE_REQ),
   .O_REMOTE_ADDR(O_REMOTE_ADDR), .O_REMOTE_DATA(O_REMOTE_DATA),
   .I_REMOTE_ACK(I_REMOTE_ACK), .O_LOCKED(O_LOCKED),
   .O_LOCK_LOST(O_LOCK_LOST), .I_PKT_VALID(I_PKT_VALID),
   .I_PKT_CRC_OK(I_PKT_CRC_OK), .I_PKT_INFO(I_PKT_INFO),
   .O_LINK_INFO(O_LINK_INFO), .O_PKT_DROPPED(O_PKT_DROPPED));
`default_nettype wire

//--- sim/deser_test_link_ctrl_tb.sv
// Self-checking bench for the test and link control register bank.
`timescale 1ns/1ps
`default_nettype none
module deser_test_link_ctrl_tb;
   logic clk, rst_n, ce, wr, rd, tpin, ldet, fwait, pv, pok;
   logic [7:0] addr, wdata, pinfo, rdata, iaddr, iwdata, raddr, rdat;
   logic [7:0] info, rsrc, got, irdata;
   logic [3:0] isel, dly;
   logic [2:0] idx, mode, errs;
   logic iwr, ird, tact, outen, rreq, rack, locked, lost, drop;
   int error_cnt = 0, n_checks = 0, lost_n = 0, drop_n = 0, rd_n = 0, kk = 0;
   // Block registers seen through the indirect port.
   assign irdata = {isel, 4'h0} ^ iaddr;
   dtl_ctrl dtl_ctrl_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
      .O_REG_RDATA(rdata), .O_IND_SEL(isel), .O_IND_ADDR(iaddr),
      .O_IND_WDATA(iwdata), .O_IND_WR(iwr), .O_IND_RD(ird),
      .I_IND_RDATA(irdata), .I_TEST_PIN(tpin), .O_TEST_ACTIVE(tact),
      .O_OUT_ENABLE(outen), .O_REMOTE_REQ(rreq), .O_REMOTE_ADDR(raddr),
      .O_REMOTE_DATA(rdat), .I_REMOTE_ACK(rack), .I_INDEX_STRAP(idx),
      .I_MODE_STRAP(mode), .I_LOCK_DETECT(ldet), .I_ERR_PARITY(errs[0]),
      .I_ERR_CLOCK(errs[1]), .I_ERR_CTRL(errs[2]), .I_FILTER_WAIT(fwait),
      .O_LOCKED(locked), .O_LOCK_LOST(lost), .I_PKT_VALID(pv),
      .I_PKT_CRC_OK(pok), .I_PKT_INFO(pinfo), .O_LINK_INFO(info),
      .O_PKT_DROPPED(drop));
   dtl_remote_model dtl_remote_model_i (.i_clk(clk), .i_rst_n(rst_n),
      .i_delay(dly), .i_req(rreq), .i_addr(raddr), .i_data(rdat),
      .o_ack(rack), .o_clk_src(rsrc));
   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Counts one-cycle pulses from the bank.
   always @(posedge clk) begin
      if (lost === 1'b1) lost_n++;
      if (drop === 1'b1) drop_n++;
      if (ird === 1'b1) rd_n++;
   end
   task give_verdict;
      if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("register read", e, rdata);
   endtask
   task t_regs;
      logic [7:0] rv [12];
      rv = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h25, 8'h00, 8'h18, 8'h00,
         8'h00, 8'h33, 8'h83, 8'h74};
      for (int i = 0; i < 12; i++)
         if (i != 8) rd_chk(8'hB0 + 8'(i), rv[i]);
      rd_chk(8'hC0, 8'h00);
      wr_reg(8'hB9, 8'hFF);
      rd_chk(8'hB9, 8'h3F);
      wr_reg(8'hB9, 8'h33);
   endtask
   task t_ind;
      for (int s = 0; s < 16; s++) begin
         wr_reg(8'hB0, 8'(s << 2));
         #1 chk("block select", 8'(s), {4'h0, isel});
      end
      wr_reg(8'hB0, 8'h16);
      wr_reg(8'hB1, 8'h10);
      for (int i = 0; i < 2; i++) begin
         wr_reg(8'hB2, 8'hA5 + 8'(i));
         #1 chk("indirect strobe", 8'h01, {7'h0, iwr});
         chk("indirect data", 8'hA5 + 8'(i), iwdata);
         chk("indirect target", 8'h10 + 8'(i), iaddr);
      end
      cyc(1);
      chk("indirect offset", 8'h12, iaddr);
      rd_chk(8'hB2, 8'h42);
      rd_chk(8'hB2, 8'h43);
      wr_reg(8'hB0, 8'h17);
      wr_reg(8'hB1, 8'h20);
      rd_chk(8'hB2, 8'h70);
      cyc(2);
      chk("prefetch strobes", 8'h02, 8'(rd_n));
   endtask
   task t_test;
      // Clock source 3 is never chosen.
      for (int m = 0; m < 4; m++) begin
         wr_reg(8'hB3, 8'h00);
         wr_reg(8'hB3, 8'(m << 6) | 8'h03);
         cyc(3);
         chk("test active", 8'h01, {7'h0, tact});
         chk("output enable", {7'h0, m == 2}, {7'h0, outen});
      end
      cyc(4);
      chk("remote source", 8'h01, rsrc);
      wr_reg(8'hB3, 8'h00);
      dly <= 4'h6;
      wr_reg(8'hB3, 8'h05);
      cyc(7);
      chk("remote pending", 8'h01, {7'h0, rreq});
      cyc(8);
      chk("remote source", 8'h02, rsrc);
      chk("remote done", 8'h00, {7'h0, rreq});
      wr_reg(8'hB3, 8'h00);
      @(posedge clk) tpin <= 1'b1;
      cyc(6);
      chk("register ignores pin", 8'h00, {7'h0, tact});
      wr_reg(8'hB3, 8'h08);
      cyc(6);
      chk("pin starts", 8'h01, {7'h0, tact});
      @(posedge clk) tpin <= 1'b0;
      cyc(20);
      chk("pin stops", 8'h00, {7'h0, tact});
      chk("outputs back", 8'h01, {7'h0, outen});
   endtask
   task burst(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk) errs <= 3'b001 << (kk % 3);
         kk++;
      end
      @(posedge clk) errs <= 3'b000;
      cyc(2);
   endtask
   task relock(input logic [7:0] pol, input logic w);
      wr_reg(8'hB9, pol);
      @(posedge clk) ldet <= 1'b0;
      @(posedge clk) ldet <= 1'b1;
      fwait <= w;
      cyc(3);
      chk("locked", 8'h01, {7'h0, locked});
   endtask
   task t_lock;
      relock(8'h33, 1'b0);
      burst(2);
      chk("two errors", 8'h01, {7'h0, locked});
      burst(1);
      chk("third error", 8'h00, {7'h0, locked});
      relock(8'h23, 1'b0);
      burst(1);
      chk("count off", 8'h00, {7'h0, locked});
      relock(8'h35, 1'b1);
      burst(6);
      chk("wait masked", 8'h01, {7'h0, locked});
      relock(8'h35, 1'b0);
      burst(4);
      relock(8'h35, 1'b0);
      burst(4);
      chk("count restarts", 8'h01, {7'h0, locked});
      burst(1);
      chk("fifth error", 8'h00, {7'h0, locked});
      relock(8'h11, 1'b1);
      burst(1);
      chk("wait counted", 8'h00, {7'h0, locked});
      chk("lost pulses", 8'h04, 8'(lost_n));
   endtask
   task pkt(input logic [7:0] d, input logic ok, input logic [7:0] e);
      @(posedge clk);
      pv <= 1'b1;
      pinfo <= d;
      pok <= ok;
      @(posedge clk) pv <= 1'b0;
      cyc(1);
      chk("link info", e, info);
   endtask
   task t_crc;
      pkt(8'h3C, 1'b0, 8'h3C);
      // Host also sets the capability flag elsewhere.
      wr_reg(8'hBA, 8'h03);
      pkt(8'hC3, 1'b0, 8'h3C);
      pkt(8'h5A, 1'b1, 8'h5A);
      chk("dropped", 8'h01, 8'(drop_n));
   endtask
   task t_strap;
      rd_chk(8'hB8, 8'hDA);
      wr_reg(8'hB8, 8'h00);
      rd_chk(8'hB8, 8'hDA);
   endtask
   // Reset, then the scenarios in turn.
   initial begin
      {rst_n, wr, rd, tpin, ldet, fwait, pv, pok, errs} = '0;
      ce = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      pinfo = 8'h00;
      dly = 4'h0;
      idx = 3'h5;
      mode = 3'h2;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_ind();
      t_test();
      t_lock();
      t_crc();
      t_strap();
      give_verdict();
   end
   // Cuts a hang short.
   initial begin
      #(40 * 20000);
      error_cnt++;
      give_verdict();
   end
endmodule // deser_test_link_ctrl_tb
`default_nettype wire
